// file: rtl/pin_routing_pkg.sv
// Constants, register map and types for the peripheral pin routing block
package pin_routing_pkg;

  // ==========================================================================
  // Bus and field layout
  localparam int          ADDR_W     = 13;
  localparam int          DATA_W     = 8;
  localparam int          SEL_W      = 6;
  localparam int          PIN_W      = 3;
  localparam int          PORT_LSB   = 3;
  localparam int          LOCK_BIT   = 0;
  localparam int          NUM_IN     = 13;
  localparam int          NUM_OUT    = 17;
  localparam int          NUM_PADS   = 24;
  localparam int          NUM_SRC    = 9;

  // ==========================================================================
  // Lock register and key sequence
  localparam logic [12:0] LOCK_ADDR  = 13'h1E8F;
  localparam logic [7:0]  LOCK_KEY1  = 8'h55;
  localparam logic [7:0]  LOCK_KEY2  = 8'hAA;
  localparam logic        LOCK_RST   = 1'b0;

  // ==========================================================================
  // Codes
  localparam logic [5:0]  SRC_LATCH  = 6'h00;
  localparam logic [5:0]  SRC_LAST   = 6'h09;
  localparam logic [2:0]  PORT_A     = 3'h0;
  localparam logic [2:0]  PORT_B     = 3'h1;
  localparam logic [2:0]  PORT_C     = 3'h2;
  localparam logic [5:0]  OUT_RST    = 6'h00;

  // ==========================================================================
  // Peripheral input selections: order is ext int, tmr0 clk, tmr1 clk,
  // tmr1 gate, tmr2 in, capture1, capture2, adc trigger, sync serial clk,
  // sync serial data, sync serial select, async receive, async clock
  localparam logic [12:0] IN_ADDR [NUM_IN] = '{
    13'h1E90, 13'h1E91, 13'h1E92, 13'h1E93, 13'h1E9C, 13'h1EA1, 13'h1EA2,
    13'h1EC3, 13'h1EC5, 13'h1EC6, 13'h1EC7, 13'h1ECB, 13'h1ECC
  };
  // Power-on defaults, {port, pin}
  localparam logic [5:0]  IN_RST [NUM_IN] = '{
    6'h02, 6'h02, 6'h05, 6'h04, 6'h05, 6'h15, 6'h13,
    6'h12, 6'h0C, 6'h0E, 6'h16, 6'h0D, 6'h0F
  };

  // ==========================================================================
  // Pin output selections: a0 a1 a2 a4 a5 b4 b5 b6 b7 c0..c7
  localparam logic [12:0] OUT_ADDR [NUM_OUT] = '{
    13'h1F10, 13'h1F11, 13'h1F12, 13'h1F14, 13'h1F15, 13'h1F1C, 13'h1F1D,
    13'h1F1E, 13'h1F1F, 13'h1F20, 13'h1F21, 13'h1F22, 13'h1F23, 13'h1F24,
    13'h1F25, 13'h1F26, 13'h1F27
  };
  // Bit of the 24-bit pad vector {port C, port B, port A} per routed pin
  localparam logic [4:0]  OUT_PAD [NUM_OUT] = '{
    5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h0C, 5'h0D,
    5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
    5'h15, 5'h16, 5'h17
  };

  // ==========================================================================
  // Lock sequence tracker
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_KEY1  = 2'b01,
    SEQ_ARMED = 2'b10
  } lock_seq_e;

endpackage

// file: rtl/peripheral_pin_routing_lock.sv
// Peripheral pin routing registers with write-protection lock
`timescale 1ns/1ps
`default_nettype none

module peripheral_pin_routing_lock
  import pin_routing_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                other_reset_i,
  input  wire logic                one_way_lock_option_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rd_data_o,
  input  wire logic [NUM_PADS-1:0] pad_in_i,
  input  wire logic [NUM_PADS-1:0] port_latch_output_i,
  input  wire logic [NUM_SRC-1:0]  periph_out_i,
  output logic      [NUM_OUT-1:0]  pin_out_o,
  output logic      [NUM_IN-1:0]   periph_in_o,
  output logic                     routing_locked_flag_o
);

  // ==========================================================================
  // Routing helpers

  function automatic logic route_out(
    input logic [SEL_W-1:0]   code,
    input logic               latch_bit,
    input logic [NUM_SRC-1:0] src
  );
    logic [3:0] idx;
    idx = code[3:0] - 4'h1;
    if (code == SRC_LATCH) begin
      route_out = latch_bit;
    end else if (code <= SRC_LAST) begin
      route_out = src[idx];
    end else begin
      // Unused codes drive low rather than float
      route_out = 1'b0;
    end
  endfunction

  function automatic logic route_in(
    input logic [SEL_W-1:0]    sel,
    input logic [NUM_PADS-1:0] pads
  );
    logic [2:0] port;
    logic [4:0] idx;
    port = sel[SEL_W-1:PORT_LSB];
    idx  = {port[1:0], sel[PIN_W-1:0]};
    if (port == PORT_A || port == PORT_B || port == PORT_C) begin
      route_in = pads[idx];
    end else begin
      route_in = 1'b0;
    end
  endfunction

  // ==========================================================================
  // State

  logic                    lock_ff;
  logic                    nxt_lock;
  lock_seq_e               seq_ff;
  lock_seq_e               nxt_seq;
  logic [SEL_W-1:0]        out_sel_ff [NUM_OUT];
  logic [SEL_W-1:0]        in_sel_ff  [NUM_IN];
  logic [DATA_W-1:0]       rd_data_ff;
  logic [DATA_W-1:0]       nxt_rd_data;
  logic [NUM_PADS-1:0]     pad_s1_ff;
  logic [NUM_PADS-1:0]     pad_s2_ff;
  logic [NUM_PADS-1:0]     pad_s3_ff;
  logic [NUM_PADS-1:0]     pad_ff;
  logic [NUM_PADS-1:0]     nxt_pad;
  logic [NUM_OUT-1:0]      pin_out_ff;
  logic [NUM_OUT-1:0]      nxt_pin_out;
  logic [NUM_IN-1:0]       periph_in_ff;
  logic [NUM_IN-1:0]       nxt_periph_in;

  // ==========================================================================
  // Address decode

  logic                    lock_hit;
  logic                    lock_wr;
  logic                    sel_wr_ok;
  logic                    other_wr;
  logic                    key1_seen;
  logic                    key2_seen;
  logic [NUM_OUT-1:0]      out_hit;
  logic [NUM_IN-1:0]       in_hit;
  logic [NUM_OUT-1:0]      out_wr;
  logic [NUM_IN-1:0]       in_wr;
  logic [DATA_W-1:0]       out_rd [NUM_OUT];
  logic [DATA_W-1:0]       in_rd  [NUM_IN];
  logic [DATA_W-1:0]       lock_rd;

  assign lock_hit  = (addr_i == LOCK_ADDR);
  assign lock_wr   = wr_i && lock_hit;
  assign other_wr  = wr_i && !lock_hit;
  assign key1_seen = (wr_data_i == LOCK_KEY1);
  assign key2_seen = (wr_data_i == LOCK_KEY2);
  assign sel_wr_ok = wr_i && !lock_ff;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out_dec
      assign out_hit[g] = (addr_i == OUT_ADDR[g]);
      assign out_wr[g]  = sel_wr_ok && out_hit[g];
      assign out_rd[g]  = out_hit[g] ? {2'b00, out_sel_ff[g]} : 8'h00;
    end
    for (g = 0; g < NUM_IN; g++) begin : g_in_dec
      assign in_hit[g] = (addr_i == IN_ADDR[g]);
      assign in_wr[g]  = sel_wr_ok && in_hit[g];
      assign in_rd[g]  = in_hit[g] ? {2'b00, in_sel_ff[g]} : 8'h00;
    end
  endgenerate

  // Flag reads back in bit 0 only
  assign lock_rd = lock_hit ? {7'h00, lock_ff} : 8'h00;

  // Unmapped and reserved addresses read as zero
  always_comb begin
    nxt_rd_data = lock_rd;
    for (int i = 0; i < NUM_OUT; i++) begin
      nxt_rd_data = nxt_rd_data | out_rd[i];
    end
    for (int i = 0; i < NUM_IN; i++) begin
      nxt_rd_data = nxt_rd_data | in_rd[i];
    end
    if (!rd_i) begin
      nxt_rd_data = 8'h00;
    end
  end

  // ==========================================================================
  // Lock key sequence

  // A write to any other address breaks the sequence; reads do not
  always_comb begin
    nxt_seq  = seq_ff;
    nxt_lock = lock_ff;
    if (other_wr) begin
      nxt_seq = SEQ_IDLE;
    end else if (lock_wr) begin
      unique case (seq_ff)
        SEQ_IDLE: begin
          nxt_seq = key1_seen ? SEQ_KEY1 : SEQ_IDLE;
        end
        SEQ_KEY1: begin
          // Second key arms the flag write
          if (key2_seen) begin
            nxt_seq = SEQ_ARMED;
          end else if (key1_seen) begin
            nxt_seq = SEQ_KEY1;
          end else begin
            nxt_seq = SEQ_IDLE;
          end
        end
        SEQ_ARMED: begin
          nxt_seq  = SEQ_IDLE;
          nxt_lock = wr_data_i[LOCK_BIT];
          if (one_way_lock_option_i && lock_ff) begin
            nxt_lock = 1'b1;
          end
        end
        default: begin
          nxt_seq = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= LOCK_RST;
      seq_ff  <= SEQ_IDLE;
    end else if (other_reset_i) begin
      lock_ff <= LOCK_RST;
      seq_ff  <= SEQ_IDLE;
    end else begin
      lock_ff <= nxt_lock;
      seq_ff  <= nxt_seq;
    end
  end

  // ==========================================================================
  // Selection registers

  // Only power-on reset restores selections; a warm reset must not
  // disturb pins that are already driving the board.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        out_sel_ff[i] <= OUT_RST;
      end
    end else if (!other_reset_i) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (out_wr[i]) begin
          out_sel_ff[i] <= wr_data_i[SEL_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_sel_ff[i] <= IN_RST[i];
      end
    end else if (!other_reset_i) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (in_wr[i]) begin
          in_sel_ff[i] <= wr_data_i[SEL_W-1:0];
        end
      end
    end
  end

  // ==========================================================================
  // Pad input synchroniser

  // Change is taken once stages two and three agree, which also
  // rejects single-cycle glitches on the pads.
  logic [NUM_PADS-1:0] pad_agree;

  assign pad_agree = ~(pad_s2_ff ^ pad_s3_ff);
  assign nxt_pad   = (pad_agree & pad_s3_ff) | (~pad_agree & pad_ff);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pad_s1_ff <= '0;
      pad_s2_ff <= '0;
      pad_s3_ff <= '0;
      pad_ff    <= '0;
    end else begin
      pad_s1_ff <= pad_in_i;
      pad_s2_ff <= pad_s1_ff;
      pad_s3_ff <= pad_s2_ff;
      pad_ff    <= nxt_pad;
    end
  end

  // ==========================================================================
  // Routing muxes

  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out_mux
      assign nxt_pin_out[g] = route_out(out_sel_ff[g],
                                        port_latch_output_i[OUT_PAD[g]],
                                        periph_out_i);
    end
    for (g = 0; g < NUM_IN; g++) begin : g_in_mux
      assign nxt_periph_in[g] = route_in(in_sel_ff[g], pad_ff);
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_ff   <= '0;
      periph_in_ff <= '0;
      rd_data_ff   <= 8'h00;
    end else begin
      pin_out_ff   <= nxt_pin_out;
      periph_in_ff <= nxt_periph_in;
      rd_data_ff   <= nxt_rd_data;
    end
  end

  // ==========================================================================
  // Outputs

  assign rd_data_o             = rd_data_ff;
  assign pin_out_o             = pin_out_ff;
  assign periph_in_o           = periph_in_ff;
  assign routing_locked_flag_o = lock_ff;

endmodule

`default_nettype wire

// file: tb/routing_lock_checker.sv
// Assertion checker for the pin routing lock block
`timescale 1ns/1ps
`default_nettype none
module routing_lock_checker
  import pin_routing_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic              other_reset_i,
  input wire logic              one_way_lock_option_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic              routing_locked_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire lk_wr = wr_i && (addr_i == LOCK_ADDR);
  // ====
  // Read path
  property p_idle; !rd_i |=> rd_data_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_rsv; rd_i |=> rd_data_o[7:6] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("upper read bits set");
  property p_lkrd;
    rd_i && addr_i == LOCK_ADDR |=> rd_data_o == {7'h00, $past(routing_locked_flag_o)};
  endproperty
  a_lkrd: assert property (p_lkrd) else $error("lock read wrong");
  // ====
  // Lock flag
  property p_hold1; routing_locked_flag_o && !lk_wr && !other_reset_i |=> routing_locked_flag_o;
  endproperty
  a_hold1: assert property (p_hold1) else $error("lock flag dropped");
  property p_hold0; !routing_locked_flag_o && !lk_wr |=> !routing_locked_flag_o; endproperty
  a_hold0: assert property (p_hold0) else $error("lock flag rose");
  property p_key;
    $changed(routing_locked_flag_o) && !$past(other_reset_i) |->
      $past(lk_wr && wr_data_i == LOCK_KEY2, 2) && $past(lk_wr && wr_data_i == LOCK_KEY1, 3)
      && routing_locked_flag_o == $past(wr_data_i[LOCK_BIT]);
  endproperty
  a_key: assert property (p_key) else $error("flag changed without keys");
  property p_oneway;
    one_way_lock_option_i && routing_locked_flag_o && !other_reset_i |=> routing_locked_flag_o;
  endproperty
  a_oneway: assert property (p_oneway) else $error("one-way lock cleared");
  property p_warm; other_reset_i |=> !routing_locked_flag_o; endproperty
  a_warm: assert property (p_warm) else $error("warm reset kept flag");
endmodule
bind peripheral_pin_routing_lock routing_lock_checker chk (.clk_sys_i, .rst_i, .other_reset_i,
  .one_way_lock_option_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .routing_locked_flag_o);
`default_nettype wire

// file: tb/pin_side_model.sv
// Model of the pads, port latches and peripheral outputs
`timescale 1ns/1ps
`default_nettype none
module pin_side_model
  import pin_routing_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                step_i,
  output logic      [NUM_PADS-1:0] pad_o,
  output logic      [NUM_PADS-1:0] latch_o,
  output logic      [NUM_SRC-1:0]  periph_o
);
  int seed = 32'h01cc;
  initial {pad_o, latch_o, periph_o} = '0;
  // New levels only on request, so settled outputs can be predicted
  always @(posedge clk_sys_i) begin
    if (step_i) begin
      {pad_o, latch_o} <= 48'({$random(seed), $random(seed)});
      periph_o <= 9'($random(seed));
    end
  end
endmodule
`default_nettype wire

// file: tb/peripheral_pin_routing_lock_bench.sv
// Self-checking bench for the pin routing lock block
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_routing_lock_bench
  import pin_routing_pkg::*;
;
  logic                clk_sys_i = 0, rst_i = 1, other_reset_i = 0, one_way_lock_option_i = 0;
  logic                wr_i = 0, rd_i = 0, step = 0, rd_d = 0, routing_locked_flag_o;
  logic [ADDR_W-1:0]   addr_i = '0;
  logic [DATA_W-1:0]   wr_data_i = '0, rd_data_o;
  logic [NUM_PADS-1:0] pad_in_i, port_latch_output_i;
  logic [NUM_SRC-1:0]  periph_out_i;
  logic [NUM_OUT-1:0]  pin_out_o;
  logic [NUM_IN-1:0]   periph_in_o;
  logic [7:0]          expq[$];
  logic [5:0]          code;
  int                  err_count = 0, n_tests = 0, seed = 32'h01cc;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  peripheral_pin_routing_lock uut (.clk_sys_i, .rst_i, .other_reset_i, .one_way_lock_option_i,
    .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .pad_in_i, .port_latch_output_i,
    .periph_out_i, .pin_out_o, .periph_in_o, .routing_locked_flag_o);
  pin_side_model pins (.clk_sys_i, .step_i(step), .pad_o(pad_in_i),
    .latch_o(port_latch_output_i), .periph_o(periph_out_i));
  // ====
  // Bus and check tasks
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, s);
      err_count++;
    end
  endtask
  task idle(input int n);
    wr_i <= 0;
    rd_i <= 0;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1;
    rd_i <= 0;
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    addr_i <= a;
    wr_i <= 0;
    rd_i <= 1;
    expq.push_back(e);
    @(posedge clk_sys_i);
  endtask
  task key(input logic [7:0] v);
    wr(LOCK_ADDR, LOCK_KEY1);
    wr(LOCK_ADDR, LOCK_KEY2);
    wr(LOCK_ADDR, v);
  endtask
  // Pads settle past the synchroniser before sampling
  task pads;
    idle(0);
    step <= 1;
    @(posedge clk_sys_i);
    step <= 0;
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask
  task defaults;
    for (int k = 0; k < NUM_OUT; k++) rd(OUT_ADDR[k], 8'h00);
    for (int k = 0; k < NUM_IN; k++) rd(IN_ADDR[k], {2'b00, IN_RST[k]});
    rd(LOCK_ADDR, 8'h00);
    rd(13'h1F13, 8'h00);
    idle(2);
  endtask
  function automatic logic exp_pin(input logic [5:0] c, input logic [4:0] p);
    if (c == SRC_LATCH) return port_latch_output_i[p];
    if (c <= SRC_LAST) return periph_out_i[c-1];
    return 1'b0;
  endfunction
  task results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // Read monitor
  always @(posedge clk_sys_i) begin
    rd_d <= rd_i;
    if (rd_d) chk("rd_data", expq.pop_front(), rd_data_o);
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    results();
  end
  // ====
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 0;
    idle(1);
    defaults();
    $display("reset test done");
    for (int k = 0; k < NUM_OUT; k++) wr(OUT_ADDR[k], {2'($random(seed)), 6'(k % 11)});
    pads();
    for (int k = 0; k < NUM_OUT; k++) begin
      // Off the edge, so the settled pin level is seen
      #1;
      code = 6'(k % 11);
      chk("pin_out", {7'h00, exp_pin(code, OUT_PAD[k])}, {7'h00, pin_out_o[k]});
      rd(OUT_ADDR[k], {2'b00, code});
    end
    $display("output test done");
    for (int p = 0; p < 4; p++) begin
      code = {3'(p), 3'($random(seed))};
      wr(IN_ADDR[p], {2'b00, code});
      pads();
      chk("periph_in", {7'h00, p < 3 ? pad_in_i[8*p+code[2:0]] : 1'b0}, {7'h00, periph_in_o[p]});
    end
    $display("input test done");
    key(8'h01);
    rd(LOCK_ADDR, 8'h01);
    wr(OUT_ADDR[0], 8'h05);
    wr(LOCK_ADDR, 8'h00);
    rd(OUT_ADDR[0], 8'h00);
    rd(LOCK_ADDR, 8'h01);
    key(8'h00);
    wr(OUT_ADDR[0], 8'h05);
    rd(OUT_ADDR[0], 8'h05);
    $display("lock test done");
    one_way_lock_option_i <= 1;
    key(8'h01);
    key(8'h00);
    rd(LOCK_ADDR, 8'h01);
    idle(0);
    other_reset_i <= 1;
    @(posedge clk_sys_i);
    other_reset_i <= 0;
    one_way_lock_option_i <= 0;
    rd(LOCK_ADDR, 8'h00);
    rd(OUT_ADDR[1], 8'h01);
    idle(2);
    rst_i <= 1;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 0;
    idle(1);
    defaults();
    $display("warm and cold reset test done");
    results();
  end
endmodule
`default_nettype wire
